/* File: hdl/isac_top.sv */
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module isac_top #(
  parameter int W            = 16,
  parameter bit ANALOG_MODEL = 1'b0
) (
  input  wire logic          mclk_in,
  input  wire logic          sys_rst_in,
  input  wire logic [7:0]    addr_in,
  input  wire logic [31:0]   wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic          pv_valid_in,
  input  wire logic [W-1:0]  pv_raw_in,
  input  wire logic          programmable_function_key_in,
  input  wire logic          event_latch_clear_in,
  output      logic [31:0]   rdata_out,
  output      logic          pv_valid_out,
  output      logic [W-1:0]  pv_out,
  output      logic [2:0]    alarm_out,
  output      logic          irq_out
);
  localparam int NA = isac_pkg::NUM_ALARMS;

  typedef struct packed {
    logic [isac_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [W-1:0]                    shift1;
    logic [W-1:0]                    shift_lo;
    logic [W-1:0]                    shift_hi;
    logic [W-1:0]                    range_lo;
    logic [W-1:0]                    range_hi;
    logic [NA-1:0][W-1:0]            alm_sv;
    logic [NA-1:0][W-1:0]            hyst;
    logic [2:0]                      level;
    logic [NA-1:0]                   status;
    logic [NA-1:0]                   mask;
    logic [W-1:0]                    pv;
    logic                            pv_vld;
    logic [NA-1:0]                   raw;
    logic [NA-1:0]                   stby;
    logic [NA-1:0]                   left;
    logic [NA-1:0]                   alm;
    logic                            irq;
    logic [31:0]                     rdata;
  } isac_state_t;

  isac_state_t s_q;
  isac_state_t s_d;

  logic signed [W-1:0] two_pt_shift;
  logic signed [W-1:0] sel_shift;
  logic signed [W:0]   shifted;
  logic [1:0]          sens_class;
  logic                use_two_pt;
  logic                lvl_enter;
  logic                latch_clr;
  logic [NA-1:0]       alm_rise;
  logic [NA-1:0]       alm_fall;
  logic [W-1:0]        hyst_rst;

  // interpolator for the two-point case; shift on the raw input position
  isac_shift #(
    .W (W)
  ) u_shift (
    .pv_in                    (pv_raw_in),
    .lower_end_shift_value_in (s_q.shift_lo),
    .upper_end_shift_value_in (s_q.shift_hi),
    .range_lo_in              (s_q.range_lo),
    .range_hi_in              (s_q.range_hi),
    .shift_out                (two_pt_shift)
  );

  // shift selection by sensor class and shift-type bit
  always_comb
  begin
    sens_class = s_q.ctrl[isac_pkg::CTRL_CLASS_LSB +: 2];
    use_two_pt = (sens_class == isac_pkg::CLASS_IR) ||
                 s_q.ctrl[isac_pkg::CTRL_TWO_PT];
    if (sens_class == isac_pkg::CLASS_ANALOG)
    begin
      sel_shift = '0;
    end
    else if (use_two_pt)
    begin
      sel_shift = two_pt_shift;
    end
    else
    begin
      sel_shift = s_q.shift1;
    end
    shifted = (W+1)'(signed'(pv_raw_in)) + (W+1)'(sel_shift);
  end

  // default hysteresis depends on the model's input family
  assign hyst_rst = ANALOG_MODEL ? isac_pkg::HYST_ANALOG_RST : isac_pkg::HYST_TEMP_RST;

  // entering a setting level clears latches and re-arms standby
  assign lvl_enter = wr_in && (addr_in == isac_pkg::ADDR_LEVEL) &&
                     (wdata_in[2:0] != s_q.level) &&
                     (wdata_in[2:0] == isac_pkg::LVL_INITIAL ||
                      wdata_in[2:0] == isac_pkg::LVL_COMMS ||
                      wdata_in[2:0] == isac_pkg::LVL_ADVANCED ||
                      wdata_in[2:0] == isac_pkg::LVL_CALIB);
  assign latch_clr = lvl_enter || programmable_function_key_in ||
                     event_latch_clear_in;

  always_comb
  begin
    s_d      = s_q;
    alm_rise = '0;
    alm_fall = '0;

    // register writes
    if (wr_in)
    begin
      unique case (addr_in)
        isac_pkg::ADDR_CTRL:     s_d.ctrl     = wdata_in[isac_pkg::CTRL_WIDTH-1:0];
        isac_pkg::ADDR_SHIFT1:   s_d.shift1   = wdata_in[W-1:0];
        isac_pkg::ADDR_SHIFT_LO: s_d.shift_lo = wdata_in[W-1:0];
        isac_pkg::ADDR_SHIFT_HI: s_d.shift_hi = wdata_in[W-1:0];
        isac_pkg::ADDR_RANGE_LO: s_d.range_lo = wdata_in[W-1:0];
        isac_pkg::ADDR_RANGE_HI: s_d.range_hi = wdata_in[W-1:0];
        isac_pkg::ADDR_LEVEL:    s_d.level    = wdata_in[2:0];
        isac_pkg::ADDR_MASK:     s_d.mask     = wdata_in[NA-1:0];
        default:
        begin
          // alarm set values and hysteresis widths, one word per alarm
          for (int i = 0; i < NA; i++)
          begin
            if (addr_in == isac_pkg::ADDR_ALM_SV0 + 8'(i * 4))
            begin
              s_d.alm_sv[i] = wdata_in[W-1:0];
            end
            if (addr_in == isac_pkg::ADDR_HYST0 + 8'(i * 4))
            begin
              s_d.hyst[i] = wdata_in[W-1:0];
            end
          end
        end
      endcase
    end

    // conditioned value, saturated so a large shift cannot wrap the sign
    s_d.pv_vld = pv_valid_in;
    if (pv_valid_in)
    begin
      if (shifted[W] != shifted[W-1])
      begin
        s_d.pv = shifted[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      end
      else
      begin
        s_d.pv = shifted[W-1:0];
      end
    end

    // alarm evaluation on each fresh conditioned value
    for (int i = 0; i < NA; i++)
    begin
      logic upper;
      logic in_rng;
      logic clr_rng;
      logic eligible;
      logic stby_en;
      logic latch_en;
      logic signed [W:0] pvx;
      logic signed [W:0] svx;
      logic signed [W:0] hx;
      upper    = s_q.ctrl[isac_pkg::CTRL_UPPER_LSB + i];
      stby_en  = s_q.ctrl[isac_pkg::CTRL_STBY_LSB + i];
      latch_en = s_q.ctrl[isac_pkg::CTRL_LATCH_LSB + i];
      pvx      = (W+1)'(signed'(s_q.pv));
      svx      = (W+1)'(signed'(s_q.alm_sv[i]));
      hx       = (W+1)'(signed'(s_q.hyst[i]));
      in_rng   = upper ? (pvx >= svx) : (pvx <= svx);
      // off only once past the set value by the full hysteresis
      clr_rng  = upper ? (pvx <= svx - hx) : (pvx >= svx + hx);
      eligible = !(stby_en && s_q.stby[i]) || s_q.left[i];
      if (s_q.pv_vld)
      begin
        if (!s_q.raw[i] && in_rng)
        begin
          s_d.raw[i] = 1'b1;
        end
        else if (s_q.raw[i] && clr_rng)
        begin
          s_d.raw[i] = 1'b0;
        end
        // leaving the range while waiting opens the way for the next entry
        if (s_q.stby[i] && !in_rng)
        begin
          s_d.left[i] = 1'b1;
        end
      end
      // a latched alarm ignores the value until cleared
      if (latch_en && s_q.alm[i] && !latch_clr)
      begin
        s_d.alm[i] = 1'b1;
      end
      else
      begin
        s_d.alm[i] = s_d.raw[i] && eligible;
      end
      alm_rise[i] = s_d.alm[i] && !s_q.alm[i];
      alm_fall[i] = !s_d.alm[i] && s_q.alm[i];
      if (alm_rise[i])
      begin
        s_d.stby[i] = 1'b0;
        s_d.left[i] = 1'b0;
      end
      // re-arm: always on level entry, and on alarm off when selected
      if (lvl_enter || (s_q.ctrl[isac_pkg::CTRL_STBY_RST] && alm_fall[i]))
      begin
        s_d.stby[i] = 1'b1;
        s_d.left[i] = 1'b0;
      end
    end

    // sticky events; a read clears, but a new event in that cycle survives
    if (rd_in && addr_in == isac_pkg::ADDR_STATUS)
    begin
      s_d.status = '0;
    end
    s_d.status = s_d.status | alm_rise;
    s_d.irq    = |(s_d.status & s_d.mask);

    // read data stand in the cycle after the strobe only
    s_d.rdata = '0;
    if (rd_in)
    begin
      unique case (addr_in)
        isac_pkg::ADDR_CTRL:     s_d.rdata = 32'(s_q.ctrl);
        isac_pkg::ADDR_SHIFT1:   s_d.rdata = 32'(signed'(s_q.shift1));
        isac_pkg::ADDR_SHIFT_LO: s_d.rdata = 32'(signed'(s_q.shift_lo));
        isac_pkg::ADDR_SHIFT_HI: s_d.rdata = 32'(signed'(s_q.shift_hi));
        isac_pkg::ADDR_RANGE_LO: s_d.rdata = 32'(signed'(s_q.range_lo));
        isac_pkg::ADDR_RANGE_HI: s_d.rdata = 32'(signed'(s_q.range_hi));
        isac_pkg::ADDR_LEVEL:    s_d.rdata = 32'(s_q.level);
        isac_pkg::ADDR_STATUS:   s_d.rdata = 32'(s_q.status);
        isac_pkg::ADDR_MASK:     s_d.rdata = 32'(s_q.mask);
        isac_pkg::ADDR_ALMSTAT:  s_d.rdata = {23'h000000, s_q.left, s_q.stby, s_q.alm};
        default:
        begin
          for (int i = 0; i < NA; i++)
          begin
            if (addr_in == isac_pkg::ADDR_ALM_SV0 + 8'(i * 4))
            begin
              s_d.rdata = 32'(signed'(s_q.alm_sv[i]));
            end
            if (addr_in == isac_pkg::ADDR_HYST0 + 8'(i * 4))
            begin
              s_d.rdata = 32'(s_q.hyst[i]);
            end
          end
        end
      endcase
    end

    // synchronous reset: power-up clears latches and arms standby
    if (sys_rst_in)
    begin
      s_d          = '0;
      s_d.ctrl     = isac_pkg::CTRL_RST;
      s_d.shift1   = isac_pkg::SHIFT_RST;
      s_d.shift_lo = isac_pkg::SHIFT_RST;
      s_d.shift_hi = isac_pkg::SHIFT_RST;
      s_d.range_lo = isac_pkg::RANGE_LO_RST;
      s_d.range_hi = isac_pkg::RANGE_HI_RST;
      s_d.level    = isac_pkg::LVL_OPERATION;
      s_d.mask     = isac_pkg::MASK_RST;
      s_d.stby     = '1;
      s_d.alm      = '0;
      for (int i = 0; i < NA; i++)
      begin
        s_d.alm_sv[i] = isac_pkg::ALM_SV_RST;
        s_d.hyst[i]   = hyst_rst;
      end
    end
  end

  // the whole state moves on every rising edge
  always_ff @(posedge mclk_in)
  begin
    s_q <= s_d;
  end

  assign rdata_out    = s_q.rdata;
  assign pv_valid_out = s_q.pv_vld;
  assign pv_out       = s_q.pv;
  assign alarm_out    = s_q.alm;
  assign irq_out      = s_q.irq;
endmodule

/* File: hdl/isac_pkg.sv */
// Behaviour
// - infrared sensor input always uses the two-point shift.
// - thermocouple or resistance input uses two-point shift only when selected.
// - analog voltage or current input gets no shift at all.
// - one-point mode adds the signed shift to every process value.
// - two-point mode holds separate lower-end and upper-end shift values.
// - mid-range shift equals the mean of the two end shifts.
// - each of three alarms has its own hysteresis width.
// - hysteresis defaults to 0.2 degree, or 0.02 percent FS on analog models.
// - standby suppresses an alarm until the value leaves then re-enters the range.
// - lower alarm with standby stays off at power-up until value rises and falls.
// - standby ends as soon as the alarm output asserts.
// - ended standby re-arms according to the standby-reset setting.
// - latched alarm stays on, whatever the value, until the latch clears.
// - latches clear at power-up and on entry to setting or calibration levels.
// - latches also clear from function key or assigned event input.
package isac_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SHIFT1   = 8'h04;
  localparam logic [7:0] ADDR_SHIFT_LO = 8'h08;
  localparam logic [7:0] ADDR_SHIFT_HI = 8'h0C;
  localparam logic [7:0] ADDR_RANGE_LO = 8'h10;
  localparam logic [7:0] ADDR_RANGE_HI = 8'h14;
  localparam logic [7:0] ADDR_ALM_SV0  = 8'h18;
  localparam logic [7:0] ADDR_HYST0    = 8'h24;
  localparam logic [7:0] ADDR_LEVEL    = 8'h30;
  localparam logic [7:0] ADDR_STATUS   = 8'h38;
  localparam logic [7:0] ADDR_MASK     = 8'h3C;
  localparam logic [7:0] ADDR_ALMSTAT  = 8'h40;
  localparam logic [7:0] ADDR_STEP     = 8'h04;
  // control register fields
  localparam int CTRL_CLASS_LSB  = 0;
  localparam int CTRL_TWO_PT     = 2;
  localparam int CTRL_STBY_LSB   = 3;
  localparam int CTRL_LATCH_LSB  = 6;
  localparam int CTRL_STBY_RST   = 9;
  localparam int CTRL_UPPER_LSB  = 10;
  localparam int CTRL_WIDTH      = 13;
  // sensor classes
  localparam logic [1:0] CLASS_TC      = 2'h0;
  localparam logic [1:0] CLASS_RTD     = 2'h1;
  localparam logic [1:0] CLASS_IR      = 2'h2;
  localparam logic [1:0] CLASS_ANALOG  = 2'h3;
  // operating levels
  localparam logic [2:0] LVL_OPERATION = 3'h0;
  localparam logic [2:0] LVL_ADJUST    = 3'h1;
  localparam logic [2:0] LVL_INITIAL   = 3'h2;
  localparam logic [2:0] LVL_COMMS     = 3'h3;
  localparam logic [2:0] LVL_ADVANCED  = 3'h4;
  localparam logic [2:0] LVL_CALIB     = 3'h5;
  // reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST  = 13'h0000;
  localparam logic [15:0] SHIFT_RST           = 16'h0000;
  localparam logic [15:0] RANGE_LO_RST        = 16'h0000;
  localparam logic [15:0] RANGE_HI_RST        = 16'h0A28;
  localparam logic [15:0] ALM_SV_RST          = 16'h0000;
  // 0.2 degree in 0.1 degree counts; 0.02 % FS in 0.01 % counts
  localparam logic [15:0] HYST_TEMP_RST       = 16'h0002;
  localparam logic [15:0] HYST_ANALOG_RST     = 16'h0002;
  localparam logic [2:0]  MASK_RST            = 3'h0;
  localparam int NUM_ALARMS = 3;
endpackage

/* File: hdl/isac_shift.sv */
`timescale 1ns/10ps
// two-point interpolated shift; combinational, registered by the caller
module isac_shift #(
  parameter int W = 16
) (
  input  wire logic signed [W-1:0] pv_in,
  input  wire logic signed [W-1:0] lower_end_shift_value_in,
  input  wire logic signed [W-1:0] upper_end_shift_value_in,
  input  wire logic signed [W-1:0] range_lo_in,
  input  wire logic signed [W-1:0] range_hi_in,
  output      logic signed [W-1:0] shift_out
);
  logic signed [31:0] span;
  logic signed [31:0] pos;
  logic signed [31:0] delta;
  logic signed [31:0] res;

  // position clamped to the range, so the shift never extrapolates past the ends
  always_comb
  begin
    span  = 32'(range_hi_in) - 32'(range_lo_in);
    pos   = 32'(pv_in) - 32'(range_lo_in);
    delta = 32'(upper_end_shift_value_in) - 32'(lower_end_shift_value_in);
    res   = 32'(lower_end_shift_value_in);
    if (pos < 0)
    begin
      pos = 0;
    end
    if (pos > span)
    begin
      pos = span;
    end
    // straight line: lower shift at 0 %, upper at 100 %, mean at 50 %
    if (span > 0)
    begin
      res = 32'(lower_end_shift_value_in) + (delta * pos) / span;
    end
    shift_out = W'(res);
  end
endmodule

/* File: tb/isac_props.sv */
`timescale 1ns/10ps
module isac_props #(
  parameter int W = 16
) (
  input wire logic         mclk_in,
  input wire logic         sys_rst_in,
  input wire logic [7:0]   addr_in,
  input wire logic [31:0]  wdata_in,
  input wire logic         wr_in,
  input wire logic         rd_in,
  input wire logic         pv_valid_in,
  input wire logic [W-1:0] pv_raw_in,
  input wire logic         programmable_function_key_in,
  input wire logic         event_latch_clear_in,
  input wire logic [31:0]  rdata_out,
  input wire logic         pv_valid_out,
  input wire logic [W-1:0] pv_out,
  input wire logic [2:0]   alarm_out,
  input wire logic         irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // steps of a sample and of a latch clear request
  sequence s_taken;
    pv_valid_in;
  endsequence
  sequence s_result;
    pv_valid_out;
  endsequence
  sequence s_clear_req;
    (programmable_function_key_in || event_latch_clear_in) && !pv_valid_out && !$past(wr_in);
  endsequence
  AST_PV_LATENCY: assert property (s_taken |=> s_result)
    else $error("process value result missing one cycle after a sample");
  AST_PV_NO_SPUR: assert property (!$past(pv_valid_in) |-> !pv_valid_out)
    else $error("process value result without a sample");
  // reset edge excluded: the value was cleared there, not by a sample
  AST_PV_HOLD: assert property ((!pv_valid_out && !$past(sys_rst_in)) |-> $stable(pv_out))
    else $error("process value moved without a result pulse");
  AST_ALARM_CAUSE: assert property (($changed(alarm_out) && !$past(sys_rst_in)) |->
      ($past(pv_valid_out) || $past(programmable_function_key_in) ||
       $past(event_latch_clear_in) || $past(wr_in) || $past(wr_in, 2)))
    else $error("alarm changed with no sample, clear or write");
  AST_ALARM_PWRUP: assert property ($past(sys_rst_in) |-> (alarm_out == 3'h0 && !irq_out))
    else $error("alarm or interrupt high after reset");
  AST_CLEAR_NO_RAISE: assert property (s_clear_req |=> ((alarm_out & ~$past(alarm_out)) == 3'h0))
    else $error("latch clear raised an alarm");
  AST_RD_IDLE: assert property ((!$past(rd_in) && !$past(sys_rst_in)) |-> rdata_out == 32'h0)
    else $error("read data not zero outside the read answer cycle");
  AST_IRQ_RISE: assert property (($rose(irq_out) && !$past(sys_rst_in)) |->
      ((alarm_out & ~$past(alarm_out)) != 3'h0 || $past(wr_in) || $past(wr_in, 2)))
    else $error("interrupt rose with no alarm rise or mask write");
endmodule

bind isac_top isac_props #(.W(W)) props_u (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .pv_valid_in(pv_valid_in), .pv_raw_in(pv_raw_in),
  .programmable_function_key_in(programmable_function_key_in),
  .event_latch_clear_in(event_latch_clear_in), .rdata_out(rdata_out),
  .pv_valid_out(pv_valid_out), .pv_out(pv_out), .alarm_out(alarm_out), .irq_out(irq_out)
);

/* File: tb/isac_sensor.sv */
`timescale 1ns/10ps
// measurement front end: one value per valid pulse, prompt or after idle cycles
module isac_sensor (
  input  wire logic   clk_in,
  output logic        pv_valid_out,
  output logic [15:0] pv_raw_out
);
  initial
  begin
    pv_valid_out = 1'b0;
    pv_raw_out   = 16'h0000;
  end
  // outside the valid cycle the data shows the inverse, so nobody may rely on it
  task automatic send(input logic [15:0] v, input int gap);
    @(posedge clk_in);
    repeat (gap) @(posedge clk_in);
    pv_valid_out <= 1'b1;
    pv_raw_out   <= v;
    @(posedge clk_in);
    pv_valid_out <= 1'b0;
    pv_raw_out   <= ~v;
  endtask
endmodule

/* File: tb/test_input_shift_alarm_conditioning.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module test_input_shift_alarm_conditioning;
  logic        mclk_in    = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wdata_in   = 32'h0000_0000;
  logic        wr_in      = 1'b0;
  logic        rd_in      = 1'b0;
  logic        key_in     = 1'b0;
  logic        evt_in     = 1'b0;
  logic        pv_valid_in;
  logic [15:0] pv_raw_in;
  logic [31:0] rdata_out;
  logic        pv_valid_out;
  logic [15:0] pv_out;
  logic [2:0]  alarm_out;
  logic        irq_out;
  logic [31:0] v;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;
  isac_top #(.W(16), .ANALOG_MODEL(1'b0)) dut_u (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .pv_valid_in(pv_valid_in), .pv_raw_in(pv_raw_in),
    .programmable_function_key_in(key_in), .event_latch_clear_in(evt_in),
    .rdata_out(rdata_out), .pv_valid_out(pv_valid_out), .pv_out(pv_out),
    .alarm_out(alarm_out), .irq_out(irq_out));
  isac_sensor sens_u (.clk_in(mclk_in), .pv_valid_out(pv_valid_in), .pv_raw_out(pv_raw_in));
  initial
  begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  // the whole run needs a few hundred cycles; this only cuts a hang short
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask
  // one sample through the block: value one cycle later, alarms the cycle after
  task automatic pv_step(input int raw, input int exp_pv, input logic [2:0] alm, input int gap);
    sens_u.send(16'(raw), gap);
    #1 `CHK("process value", 16'(exp_pv), pv_out)
    `CHK("result pulse", 1'b1, pv_valid_out)
    @(posedge mclk_in);
    #1 `CHK("alarm outputs", alm, alarm_out)
    `CHK("result pulse end", 1'b0, pv_valid_out)
  endtask
  task automatic t_reset_values();
    rd_reg(isac_pkg::ADDR_CTRL, v);
    `CHK("control reset", 32'h0000_0000, v)
    rd_reg(isac_pkg::ADDR_HYST0 + 8'h08, v);
    `CHK("hysteresis reset", 32'h0000_0002, v)
    rd_reg(8'h50, v);
    `CHK("unmapped read", 32'h0000_0000, v)
    `CHK("alarms at power up", 3'h0, alarm_out)
  endtask
  task automatic t_shift();
    int exp_pv[8] = '{1012, 1012, 1020, 1000, 1020, 1020, 1020, 1000};
    wr_reg(isac_pkg::ADDR_SHIFT1, 32'h0000_000C);
    wr_reg(isac_pkg::ADDR_SHIFT_LO, 32'h0000_000A);
    wr_reg(isac_pkg::ADDR_SHIFT_HI, 32'h0000_001E);
    wr_reg(isac_pkg::ADDR_RANGE_HI, 32'h0000_07D0);
    // every class with and without the two-point select; mid range gives the mean
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(isac_pkg::ADDR_CTRL, 32'(i));
      pv_step(1000, exp_pv[i], 3'h0, i % 3);
    end
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0002);
    pv_step(0, 10, 3'h0, 0);
    pv_step(2000, 2030, 3'h0, 0);
    pv_step(500, 515, 3'h0, 0);
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0000);
    wr_reg(isac_pkg::ADDR_SHIFT1, 32'hFFFF_FFFB);
    pv_step(1000, 995, 3'h0, 0);
    wr_reg(isac_pkg::ADDR_SHIFT1, 32'h0000_0000);
  endtask
  task automatic t_hyst();
    wr_reg(isac_pkg::ADDR_HYST0, 32'h0000_0005);
    wr_reg(isac_pkg::ADDR_HYST0 + 8'h04, 32'h0000_0014);
    wr_reg(isac_pkg::ADDR_ALM_SV0, 32'h0000_0064);
    wr_reg(isac_pkg::ADDR_ALM_SV0 + 8'h04, 32'h0000_0064);
    wr_reg(isac_pkg::ADDR_ALM_SV0 + 8'h08, 32'h0000_0032);
    wr_reg(isac_pkg::ADDR_MASK, 32'h0000_0001);
    pv_step(100, 100, 3'h3, 0);
    `CHK("interrupt on rise", 1'b1, irq_out)
    pv_step(104, 104, 3'h3, 0);
    pv_step(105, 105, 3'h2, 0);
    rd_reg(isac_pkg::ADDR_STATUS, v);
    `CHK("status", 32'h0000_0003, v)
    `CHK("interrupt after read", 1'b0, irq_out)
    pv_step(119, 119, 3'h2, 0);
    pv_step(120, 120, 3'h0, 0);
    wr_reg(isac_pkg::ADDR_MASK, 32'h0000_0000);
    pv_step(50, 50, 3'h7, 0);
    `CHK("masked interrupt", 1'b0, irq_out)
    wr_reg(isac_pkg::ADDR_MASK, 32'h0000_0004);
    repeat (2) @(posedge mclk_in);
    #1 `CHK("unmasked interrupt", 1'b1, irq_out)
    rd_reg(isac_pkg::ADDR_STATUS, v);
    `CHK("status", 32'h0000_0007, v)
    // upper-type alarms 0 and 1: off only at or below set value minus hysteresis
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0C00);
    pv_step(150, 150, 3'h3, 0);
    pv_step(96, 96, 3'h3, 0);
    pv_step(95, 95, 3'h2, 0);
  endtask
  task automatic t_standby();
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    #1 `CHK("alarms in reset", 3'h0, alarm_out)
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0008);
    wr_reg(isac_pkg::ADDR_ALM_SV0, 32'h0000_0064);
    pv_step(50, 50, 3'h0, 0);
    pv_step(150, 150, 3'h0, 0);
    pv_step(60, 60, 3'h1, 0);
    pv_step(150, 150, 3'h0, 0);
    pv_step(60, 60, 3'h1, 0);
    pv_step(150, 150, 3'h0, 0);
    wr_reg(isac_pkg::ADDR_LEVEL, 32'(isac_pkg::LVL_INITIAL));
    wr_reg(isac_pkg::ADDR_LEVEL, 32'(isac_pkg::LVL_OPERATION));
    pv_step(60, 60, 3'h0, 0);
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0208);
    pv_step(150, 150, 3'h0, 0);
    pv_step(60, 60, 3'h1, 0);
    pv_step(150, 150, 3'h0, 0);
    pv_step(60, 60, 3'h0, 0);
  endtask
  task automatic t_latch();
    wr_reg(isac_pkg::ADDR_CTRL, 32'h0000_0040);
    pv_step(60, 60, 3'h1, 0);
    pv_step(150, 150, 3'h1, 0);
    @(posedge mclk_in);
    key_in <= 1'b1;
    @(posedge mclk_in);
    key_in <= 1'b0;
    @(posedge mclk_in);
    #1 `CHK("latch after key", 3'h0, alarm_out)
    pv_step(60, 60, 3'h1, 0);
    @(posedge mclk_in);
    evt_in <= 1'b1;
    @(posedge mclk_in);
    evt_in <= 1'b0;
    @(posedge mclk_in);
    #1 `CHK("in range after event", 3'h1, alarm_out)
    pv_step(150, 150, 3'h1, 0);
    wr_reg(isac_pkg::ADDR_LEVEL, 32'(isac_pkg::LVL_ADJUST));
    repeat (2) @(posedge mclk_in);
    #1 `CHK("latch kept in adjust", 3'h1, alarm_out)
    // initial, comms, advanced and calibration each clear the latch on entry
    for (int l = 2; l <= 5; l++)
    begin
      wr_reg(isac_pkg::ADDR_LEVEL, 32'(isac_pkg::LVL_OPERATION));
      pv_step(60, 60, 3'h1, 0);
      pv_step(150, 150, 3'h1, 0);
      wr_reg(isac_pkg::ADDR_LEVEL, 32'(l));
      repeat (2) @(posedge mclk_in);
      #1 `CHK("latch after level entry", 3'h0, alarm_out)
    end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    t_reset_values();
    t_shift();
    t_hyst();
    t_standby();
    t_latch();
    end_of_test();
  end
endmodule
